// ==== rtl/prws_cfg.svh ====
// Function
// - Hold power-on reset until battery supply is above minimum threshold.
// - Core regulator enabled only once power-on reset is released.
// - In run mode, reset the device when battery supply falls below threshold.
// - In run mode, reset when digital core supply drops below threshold.
// - Supervisor off in standby and sleep; no under-voltage resets there.
// - Start-up delays internal; unconnected reset pin counts as deasserted.
// - External reset pin resets the whole digital subsystem and core.
// - Real-time clock counters are not reset by the external pin.
// - External reset pin acts only in run mode and during power-on reset.
// - Pin held during power-on keeps processor in reset until released.
// - Any of five wake events (four pins, enabled alarm) moves standby or sleep into run mode.
// - Wake pins fall_a and fall_b wake on a high-to-low transition.
// - Wake pins rise_a and rise_b wake on a low-to-high transition.
// - Enabled real-time clock alarm acts as a wake source.
// - Software control enables or disables the analog converter regulator.
// - Wake from sleep resets system; real-time clock state is kept.
// - Wake from standby resumes execution with all state retained.
// - Real-time clock reset only by power-on, not by digital resets.
`ifndef PRWS_CFG_SVH
`define PRWS_CFG_SVH
`define PRWS_STARTUP_NS 1000
`define PRWS_CLK_NS 8
`define PRWS_STARTUP_CYC ((`PRWS_STARTUP_NS + `PRWS_CLK_NS - 1) / `PRWS_CLK_NS)
`define PRWS_CNT_W 8
`define PRWS_WAKE_N 4
`define PRWS_WAKE_IDLE 4'h3
`endif

// ==== rtl/prws_pkg.sv ====
package prws_pkg;
   typedef enum logic [1:0] {
      PRWS_OFF,
      PRWS_RUN,
      PRWS_STANDBY,
      PRWS_SLEEP
   } prws_mode_e;
endpackage

// ==== rtl/prws_sequencer.sv ====
`timescale 1ns/10ps
`include "prws_cfg.svh"
module prws_sequencer (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic battery_ok,
   input wire logic core_supply_ok,
   input wire logic external_reset_n_pin,
   input wire logic wake_pin_fall_a,
   input wire logic wake_pin_fall_b,
   input wire logic wake_pin_rise_a,
   input wire logic wake_pin_rise_b,
   input wire logic rtc_alarm,
   input wire logic rtc_alarm_wake_en,
   input wire logic req_standby,
   input wire logic req_sleep,
   input wire logic analog_reg_en,
   output logic por_n,
   output logic sys_reset_n,
   output logic rtc_reset_n,
   output logic core_reg_en,
   output logic core_reg_low,
   output logic analog_converter_supply_en,
   output logic supervisor_en,
   output logic cpu_paused,
   output logic [1:0] mode
);
   prws_pkg::prws_mode_e state;
   prws_pkg::prws_mode_e next_state;
   logic bat_s1, bat_s2, core_s1, core_s2, pin_s1, pin_s2;
   logic [`PRWS_CNT_W-1:0] cnt;
   logic pin_rst;
   logic brownout;
   logic wake;
   logic sleep_wake;
   logic [`PRWS_CNT_W-1:0] startup_cyc;
   prws_wake_if wif ();

   assign startup_cyc = `PRWS_CNT_W'(`PRWS_STARTUP_CYC);

   // Reset on pin powers up high, so a floating pin reads deasserted
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bat_s1 <= 1'b0;
         bat_s2 <= 1'b0;
         core_s1 <= 1'b0;
         core_s2 <= 1'b0;
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         bat_s1 <= battery_ok;
         bat_s2 <= bat_s1;
         core_s1 <= core_supply_ok;
         core_s2 <= core_s1;
         pin_s1 <= external_reset_n_pin;
         pin_s2 <= pin_s1;
      end
   end

   assign supervisor_en = (state == prws_pkg::PRWS_RUN)
      || (state == prws_pkg::PRWS_OFF);
   assign brownout = supervisor_en && (!bat_s2
      || (state == prws_pkg::PRWS_RUN && !core_s2));
   assign pin_rst = !pin_s2 && (state == prws_pkg::PRWS_RUN
      || state == prws_pkg::PRWS_OFF);

   assign wif.pins = {wake_pin_rise_b, wake_pin_rise_a,
      wake_pin_fall_b, wake_pin_fall_a};
   assign wif.alarm = rtc_alarm;
   assign wif.alarm_en = rtc_alarm_wake_en;
   assign wif.armed = (state == prws_pkg::PRWS_STANDBY)
      || (state == prws_pkg::PRWS_SLEEP);
   assign wake = wif.wake;

   prws_wake_det u_wake (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wif(wif)
   );

   always_comb begin
      next_state = state;
      case (state)
         prws_pkg::PRWS_OFF: begin
            if (bat_s2 && cnt == startup_cyc)
               next_state = prws_pkg::PRWS_RUN;
         end
         prws_pkg::PRWS_RUN: begin
            if (brownout)
               next_state = prws_pkg::PRWS_OFF;
            else if (req_sleep)
               next_state = prws_pkg::PRWS_SLEEP;
            else if (req_standby)
               next_state = prws_pkg::PRWS_STANDBY;
         end
         prws_pkg::PRWS_STANDBY, prws_pkg::PRWS_SLEEP: begin
            if (wake)
               next_state = prws_pkg::PRWS_RUN;
         end
         default: next_state = prws_pkg::PRWS_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         state <= prws_pkg::PRWS_OFF;
      else
         state <= next_state;
   end

   // Start-up delay counts from supply good
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         cnt <= '0;
      else if (state != prws_pkg::PRWS_OFF || !bat_s2)
         cnt <= '0;
      else if (cnt != startup_cyc)
         cnt <= cnt + `PRWS_CNT_W'(1);
   end

   assign sleep_wake = (state == prws_pkg::PRWS_SLEEP) && wake;

   // Outputs registered; release follows the clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         por_n <= 1'b0;
         sys_reset_n <= 1'b0;
         rtc_reset_n <= 1'b0;
         core_reg_en <= 1'b0;
      end else begin
         por_n <= (next_state != prws_pkg::PRWS_OFF);
         core_reg_en <= (next_state != prws_pkg::PRWS_OFF)
            && (next_state != prws_pkg::PRWS_SLEEP);
         rtc_reset_n <= (next_state != prws_pkg::PRWS_OFF)
            || rtc_reset_n;
         sys_reset_n <= (next_state != prws_pkg::PRWS_OFF) && !pin_rst
            && !sleep_wake;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         core_reg_low <= 1'b0;
         cpu_paused <= 1'b0;
         analog_converter_supply_en <= 1'b0;
         mode <= 2'h0;
      end else begin
         core_reg_low <= (next_state == prws_pkg::PRWS_STANDBY);
         cpu_paused <= (next_state == prws_pkg::PRWS_STANDBY);
         analog_converter_supply_en <= analog_reg_en
            && (next_state == prws_pkg::PRWS_RUN);
         mode <= 2'(next_state);
      end
   end

   // The supervisor is off in low power, so a low battery there is ignored
   a_por_holds: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      supervisor_en && !bat_s2 |=> !por_n)
      else $error("por released without battery");
   a_reg_follow: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !por_n |-> !core_reg_en)
      else $error("regulator on during por");
   a_core_drop: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == prws_pkg::PRWS_RUN && !core_s2 |=> !sys_reset_n)
      else $error("core brownout missed");
   a_low_power_quiet: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wif.armed && !wake |=> sys_reset_n)
      else $error("reset in low power");
   a_pin_reset: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pin_rst |=> !sys_reset_n)
      else $error("pin reset missed");
   a_rtc_kept: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rtc_reset_n |=> rtc_reset_n)
      else $error("rtc reset by digital reset");
   a_sleep_boot: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      sleep_wake |=> !sys_reset_n ##1 sys_reset_n)
      else $error("sleep wake no reboot");
   a_analog_gate: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == prws_pkg::PRWS_RUN && analog_reg_en
      && next_state == prws_pkg::PRWS_RUN |=> analog_converter_supply_en)
      else $error("analog regulator not enabled");
   c_boot: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(por_n));
   c_standby_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state == prws_pkg::PRWS_STANDBY && wake);
   c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
      sleep_wake);
   c_brownout: cover property (@(posedge clk_sys) disable iff (!rst_n)
      brownout);
endmodule

// ==== rtl/prws_wake_det.sv ====
`timescale 1ns/10ps
`include "prws_cfg.svh"
module prws_wake_det (
   input wire logic clk_sys,
   input wire logic rst_n,
   prws_wake_if.det wif
);
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] prev;
   logic [3:0] fall;
   logic [3:0] rise;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Idle pin levels, so release of reset shows no false edge
         sync1 <= `PRWS_WAKE_IDLE;
         sync2 <= `PRWS_WAKE_IDLE;
         prev <= `PRWS_WAKE_IDLE;
      end else begin
         sync1 <= wif.pins;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign fall = prev & ~sync2;
   assign rise = ~prev & sync2;
   // Bits 0,1 falling; bits 2,3 rising
   assign wif.wake = wif.armed & (fall[0] | fall[1]
      | rise[2] | rise[3]
      | (wif.alarm_en & wif.alarm));

   a_fall_wake: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wif.armed && $fell(sync2[0]) |-> wif.wake)
      else $error("fall edge did not wake");
   a_rise_wake: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wif.armed && $rose(sync2[3]) |-> wif.wake)
      else $error("rise edge did not wake");
endmodule

// ==== rtl/prws_wake_if.sv ====
`timescale 1ns/10ps
interface prws_wake_if;
   logic [3:0] pins;
   logic alarm;
   logic alarm_en;
   logic armed;
   logic wake;
   modport ctl (output pins, output alarm, output alarm_en, output armed,
      input wake);
   modport det (input pins, input alarm, input alarm_en, input armed,
      output wake);
endinterface

// ==== sim/prws_far_model.sv ====
`timescale 1ns/10ps
module prws_far_model (
   input wire logic clk_sys,
   output logic battery_ok,
   output logic core_supply_ok,
   output logic external_reset_n_pin,
   output logic [3:0] wake,
   output logic rtc_alarm
);
   // Falling-edge pins idle high, rising-edge pins idle low
   initial begin
      battery_ok = 1'b0;
      core_supply_ok = 1'b0;
      external_reset_n_pin = 1'b1;
      wake = 4'h3;
      rtc_alarm = 1'b0;
   end
   task set_supply(input logic b, input logic c);
      @(posedge clk_sys);
      battery_ok <= b;
      core_supply_ok <= c;
   endtask
   // Holding the pin low in run mode or power-on reset keeps the core in reset for as long as we like
   task set_pin(input logic v);
      @(posedge clk_sys);
      external_reset_n_pin <= v;
   endtask
   // Index 4 is the alarm; a pin gets one active edge, then returns idle
   task pulse(input int i);
      @(posedge clk_sys);
      if (i < 4) wake[i] <= ~wake[i];
      else rtc_alarm <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wake <= 4'h3;
      rtc_alarm <= 1'b0;
   endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   logic clk_sys, rst_n, req_standby, req_sleep, rtc_alarm_wake_en;
   logic analog_reg_en, battery_ok, core_supply_ok, external_reset_n_pin;
   logic rtc_alarm, por_n, sys_reset_n, rtc_reset_n, core_reg_en;
   logic core_reg_low, analog_converter_supply_en, supervisor_en, cpu_paused;
   logic [3:0] wake;
   logic [1:0] mode;
   int fails = 0;
   int checks = 0;
   int lows = 0;
   prws_far_model far (.clk_sys, .battery_ok, .core_supply_ok,
      .external_reset_n_pin, .wake, .rtc_alarm);
   prws_sequencer dut (.clk_sys, .rst_n, .battery_ok, .core_supply_ok,
      .external_reset_n_pin, .wake_pin_fall_a(wake[0]),
      .wake_pin_fall_b(wake[1]), .wake_pin_rise_a(wake[2]),
      .wake_pin_rise_b(wake[3]), .rtc_alarm, .rtc_alarm_wake_en,
      .req_standby, .req_sleep, .analog_reg_en, .por_n, .sys_reset_n,
      .rtc_reset_n, .core_reg_en, .core_reg_low, .analog_converter_supply_en,
      .supervisor_en, .cpu_paused, .mode);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Counts cycles of digital reset, to tell a reboot from a resume
   always @(posedge clk_sys) if (sys_reset_n === 1'b0) lows <= lows + 1;
   task summarize;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [1:0] got, input logic [1:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   // sel: 0 por_n, 1 sys_reset_n, 2 mode
   task wait_for(input int sel, input logic [1:0] v);
      logic [1:0] got;
      for (int n = 0; n < 400; n++) begin
         @(posedge clk_sys);
         #1;
         got = sel == 0 ? {1'b0, por_n}
            : sel == 1 ? {1'b0, sys_reset_n} : mode;
         if (got === v) return;
      end
      fails++;
      $display("MISMATCH %0t wait timed out", $time);
      summarize();
   endtask
   task t_power_up(input logic hold);
      far.set_pin(~hold);
      repeat (200) @(posedge clk_sys);
      #1 chk(por_n, 2'h0, "por released without battery");
      chk(core_reg_en, 2'h0, "regulator on during por");
      far.set_supply(1'b1, 1'b1);
      wait_for(0, 2'h1);
      repeat (3) @(posedge clk_sys);
      #1 chk(core_reg_en, 2'h1, "regulator off after por");
      if (hold) begin
         repeat (50) @(posedge clk_sys);
         #1 chk(sys_reset_n, 2'h0, "core ran with pin held");
         far.set_pin(1'b1);
      end
      wait_for(1, 2'h1);
      wait_for(2, prws_pkg::PRWS_RUN);
      chk(analog_converter_supply_en, 2'h1, "analog supply off");
      chk(supervisor_en, 2'h1, "supervisor off in run");
   endtask
   task t_fault(input int kind);
      if (kind == 0) far.set_supply(1'b0, 1'b1);
      else if (kind == 1) far.set_supply(1'b1, 1'b0);
      else far.set_pin(1'b0);
      repeat (8) @(posedge clk_sys);
      #1 chk(sys_reset_n, 2'h0, "no reset on fault");
      // Only the power-on reset input clears the clock reset
      chk(rtc_reset_n, 2'h1, "rtc reset wrong");
      chk(mode, {1'b0, kind == 2}, "mode wrong after fault");
      if (kind == 0) return;
      far.set_supply(1'b1, 1'b1);
      far.set_pin(1'b1);
      wait_for(1, 2'h1);
      wait_for(2, prws_pkg::PRWS_RUN);
   endtask
   task t_lowpower(input logic deep, input int src);
      int l;
      @(posedge clk_sys);
      req_sleep <= deep;
      req_standby <= ~deep;
      wait_for(2, deep ? prws_pkg::PRWS_SLEEP : prws_pkg::PRWS_STANDBY);
      @(posedge clk_sys);
      req_sleep <= 1'b0;
      req_standby <= 1'b0;
      #1 chk(supervisor_en, 2'h0, "supervisor on");
      chk(analog_converter_supply_en, 2'h0, "analog supply on");
      chk(cpu_paused, {1'b0, ~deep}, "pause wrong");
      chk(core_reg_low, {1'b0, ~deep}, "core regulator level wrong");
      far.set_supply(1'b1, 1'b0);
      far.set_pin(1'b0);
      repeat (10) @(posedge clk_sys);
      #1 chk(sys_reset_n, 2'h1, "reset in low power");
      far.set_supply(1'b1, 1'b1);
      far.set_pin(1'b1);
      l = lows;
      far.pulse(src);
      wait_for(2, prws_pkg::PRWS_RUN);
      repeat (4) @(posedge clk_sys);
      #1 chk({1'b0, lows != l}, {1'b0, deep}, "wake reset wrong");
      chk(rtc_reset_n, 2'h1, "rtc reset on wake");
   endtask
   initial begin
      rst_n = 1'b0;
      req_standby = 1'b0;
      req_sleep = 1'b0;
      rtc_alarm_wake_en = 1'b1;
      analog_reg_en = 1'b1;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_power_up(1'b0);
      t_fault(1);
      t_fault(2);
      for (int s = 0; s < 5; s++) t_lowpower(s[0], s);
      t_fault(0);
      t_power_up(1'b1);
      summarize();
   end
endmodule
